// >>> rtl/caf_filter.sv
// two-channel can receive acceptance filter with a classic wishbone register slave
`timescale 1ns/1ps
module caf_filter
   import caf_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // decoded frames from the controller receive path
   input  wire logic        rx_valid_i,
   input  wire logic        rx_chan_i,
   input  wire logic [28:0] rx_id_i,
   input  wire logic        rx_ext_i,
   input  wire logic        rx_rtr_i,
   input  wire logic        rx_err_i,
   // controller transmit requests, 0 = dominant
   input  wire logic [1:0]  ctl_tx_i,
   // frames to the recording path
   output logic             rec_valid_o,
   output logic             rec_chan_o,
   output logic      [28:0] rec_id_o,
   output logic             rec_ext_o,
   output logic             rec_rtr_o,
   output logic             rec_err_o,
   // bus drive toward the transceivers, 1 = recessive
   output logic      [1:0]  can_tx_o
);

   // ==========================================================
   // configuration storage
   logic [30:0] ctrl_q [NUM_CH];
   logic [31:0] acc_q  [NUM_CH][NUM_GRP];
   logic [31:0] msk_q  [NUM_CH][NUM_GRP];
   logic [15:0] hit_cnt_q  [NUM_CH];
   logic [15:0] drop_cnt_q [NUM_CH];
   logic [1:0]  tbad;

   logic        req;
   logic        wr;
   logic        flt_sel;
   logic [2:0]  flt_grp;
   logic        flt_ch;
   logic [31:0] rd_d;
   logic [31:0] ctrl_wd;
   logic [1:0]  st_clr;
   logic [1:0]  st_cnt;
   logic        ch_en_rx;
   logic [7:0]  grp_en_rx;
   logic [31:0] cw;
   logic        hit;
   logic        pass;

   assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr      = req & wb_we_i;
   assign flt_sel = (wb_adr_i[7:6] == IDX_FLT_HI) & ~wb_adr_i[5];
   assign flt_ch  = wb_adr_i[4];
   assign flt_grp = wb_adr_i[3:1];
   assign ctrl_wd = apply_sel({1'b0, ctrl_q[wb_adr_i[0]]}, wb_dat_i, wb_sel_i);

   // timing sanity flag; the hardware trusts software here and only reports
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         tbad[c] = ctrl_q[c][CTRL_TSEG2_LSB +: 3] <
                   {1'b0, ctrl_q[c][CTRL_SJW_LSB +: 2]};
      end
   end

   // ==========================================================
   // wishbone: one-cycle registered answer, unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   always_comb begin
      rd_d = 32'h0000_0000;
      if (flt_sel) begin
         rd_d = wb_adr_i[0] ? msk_q[flt_ch][flt_grp] : acc_q[flt_ch][flt_grp];
      end else begin
         unique case (wb_adr_i)
            IDX_CTRL0: rd_d = {tbad[0], ctrl_q[0]};
            IDX_CTRL1: rd_d = {tbad[1], ctrl_q[1]};
            IDX_STAT0: rd_d = {drop_cnt_q[0], hit_cnt_q[0]};
            IDX_STAT1: rd_d = {drop_cnt_q[1], hit_cnt_q[1]};
            default:   rd_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req) begin
         wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int c = 0; c < NUM_CH; c++) begin
            ctrl_q[c] <= CTRL_RST;
         end
      end else if (wr && !flt_sel && wb_adr_i[7:1] == IDX_CTRL0[7:1]) begin
         ctrl_q[wb_adr_i[0]] <= ctrl_wd[30:0] & CTRL_WMASK;
      end
   end

   // each channel owns its eight acceptance/mask pairs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int c = 0; c < NUM_CH; c++) begin
            for (int g = 0; g < NUM_GRP; g++) begin
               acc_q[c][g] <= ACC_RST;
               msk_q[c][g] <= MSK_RST;
            end
         end
      end else if (wr && flt_sel) begin
         if (wb_adr_i[0]) begin
            msk_q[flt_ch][flt_grp] <= apply_sel(msk_q[flt_ch][flt_grp], wb_dat_i,
                                                wb_sel_i);
         end else begin
            acc_q[flt_ch][flt_grp] <= apply_sel(acc_q[flt_ch][flt_grp], wb_dat_i,
                                                wb_sel_i);
         end
      end
   end

   // ==========================================================
   // frame evaluation
   assign ch_en_rx  = ctrl_q[rx_chan_i][CTRL_EN_BIT];
   assign grp_en_rx = ctrl_q[rx_chan_i][CTRL_GRP_LSB +: 8];
   assign cw        = cmp_word(rx_id_i, rx_ext_i, rx_rtr_i);

   always_comb begin
      hit = 1'b0;
      for (int g = 0; g < NUM_GRP; g++) begin
         // selector bits take part like any other bit, so remote and format pick falls out
         if (grp_en_rx[g] && grp_match(acc_q[rx_chan_i][g], msk_q[rx_chan_i][g], cw)) begin
            hit = 1'b1;
         end
      end
   end

   always_comb begin
      pass = 1'b0;
      if (rx_valid_i && ch_en_rx) begin
         if (rx_err_i) begin
            pass = ctrl_q[rx_chan_i][CTRL_ERREC_BIT];
         end else begin
            pass = hit;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rec_valid_o <= 1'b0;
         rec_chan_o  <= 1'b0;
         rec_id_o    <= 29'h0000_0000;
         rec_ext_o   <= 1'b0;
         rec_rtr_o   <= 1'b0;
         rec_err_o   <= 1'b0;
      end else begin
         rec_valid_o <= pass;
         if (pass) begin
            rec_chan_o <= rx_chan_i;
            rec_id_o   <= rx_id_i;
            rec_ext_o  <= rx_ext_i;
            rec_rtr_o  <= rx_rtr_i;
            rec_err_o  <= rx_err_i;
         end
      end
   end

   // counters clear on a status write; a frame in that same cycle still counts
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         st_clr[c] = wr && !flt_sel && wb_adr_i == (c == 0 ? IDX_STAT0 : IDX_STAT1);
         st_cnt[c] = rx_valid_i && !rx_err_i && ch_en_rx && rx_chan_i == c[0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int c = 0; c < NUM_CH; c++) begin
            hit_cnt_q[c]  <= CNT_RST;
            drop_cnt_q[c] <= CNT_RST;
         end
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            hit_cnt_q[c]  <= (st_clr[c] ? CNT_RST : hit_cnt_q[c])
                             + {15'h0000, st_cnt[c] & hit};
            drop_cnt_q[c] <= (st_clr[c] ? CNT_RST : drop_cnt_q[c])
                             + {15'h0000, st_cnt[c] & ~hit};
         end
      end
   end

   // ==========================================================
   // bus drive: listen-only or disabled channels stay recessive, acks included
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         can_tx_o <= 2'h3;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            can_tx_o[c] <= (ctrl_q[c][CTRL_EN_BIT] && !ctrl_q[c][CTRL_LISTEN_BIT]) ?
                           ctl_tx_i[c] : 1'b1;
         end
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_disabled_no_rec: assert property (
      rx_valid_i && !ch_en_rx |=> !rec_valid_o)
      else $error("frame recorded on a disabled channel");

   a_err_frame_drop: assert property (
      rx_valid_i && rx_err_i && !ctrl_q[rx_chan_i][CTRL_ERREC_BIT] |=> !rec_valid_o)
      else $error("error frame recorded while error recording is off");

   a_err_frame_fwd: assert property (
      rx_valid_i && rx_err_i && ch_en_rx && ctrl_q[rx_chan_i][CTRL_ERREC_BIT]
      |=> rec_valid_o && rec_err_o && rec_chan_o == $past(rx_chan_i))
      else $error("error frame not forwarded");

   a_mask_zero_pass: assert property (
      rx_valid_i && !rx_err_i && ch_en_rx && grp_en_rx[0]
      && msk_q[rx_chan_i][0] == 32'h0000_0000 |=> rec_valid_o)
      else $error("all-zero mask group did not pass the frame");

   a_remote_reject: assert property (
      rx_valid_i && !rx_err_i && !rx_rtr_i && grp_en_rx == 8'h01
      && msk_q[rx_chan_i][0][CW_REM_BIT] && acc_q[rx_chan_i][0][CW_REM_BIT]
      |=> !rec_valid_o)
      else $error("data frame passed a remote-only group");

   a_ext_reject: assert property (
      rx_valid_i && !rx_err_i && !rx_ext_i && grp_en_rx == 8'h01
      && msk_q[rx_chan_i][0][CW_EXT_BIT] && acc_q[rx_chan_i][0][CW_EXT_BIT]
      |=> !rec_valid_o)
      else $error("standard frame passed an extended-only group");

   a_std_id_match: assert property (
      rx_valid_i && !rx_err_i && !rx_ext_i && ch_en_rx && grp_en_rx[0]
      && msk_q[rx_chan_i][0] == 32'h3ff8_0000
      && acc_q[rx_chan_i][0][29:19] == rx_id_i[10:0]
      |=> rec_valid_o && rec_id_o[10:0] == $past(rx_id_i[10:0]))
      else $error("standard identifier at bits 29..19 did not match");

   a_ext_bit1_used: assert property (
      rx_valid_i && !rx_err_i && rx_ext_i && grp_en_rx == 8'h01
      && msk_q[rx_chan_i][0] == 32'h0000_0002
      && acc_q[rx_chan_i][0][1] != rx_id_i[0] |=> !rec_valid_o)
      else $error("extended identifier bit 0 not compared at bit 1");

   a_ack_single: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("wishbone ack held longer than one cycle");

   a_wb_answer: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("wishbone request not answered in one cycle");

   a_no_group_drop: assert property (
      rx_valid_i && !rx_err_i && grp_en_rx == 8'h00 |=> !rec_valid_o)
      else $error("frame recorded with no configured group");

   a_stat_clear: assert property (
      wr && !flt_sel && wb_adr_i == IDX_STAT0 && !rx_valid_i
      |=> hit_cnt_q[0] == CNT_RST && drop_cnt_q[0] == CNT_RST)
      else $error("status write did not clear channel 0 counters");

   a_rec_fields: assert property (
      rx_valid_i && !rx_err_i && ch_en_rx && hit
      |=> rec_valid_o && rec_id_o == $past(rx_id_i) && rec_ext_o == $past(rx_ext_i)
          && rec_rtr_o == $past(rx_rtr_i))
      else $error("accepted frame not copied to the recording path");

   for (genvar c = 0; c < NUM_CH; c++) begin : g_tx_chk
      sequence s_silent;
         !ctrl_q[c][CTRL_EN_BIT] || ctrl_q[c][CTRL_LISTEN_BIT];
      endsequence
      a_listen_quiet: assert property (
         s_silent ##1 s_silent |-> can_tx_o[c])
         else $error("listen-only or disabled channel drove the bus");
      a_tx_follow: assert property (
         ctrl_q[c][CTRL_EN_BIT] && !ctrl_q[c][CTRL_LISTEN_BIT]
         |=> can_tx_o[c] == $past(ctl_tx_i[c]))
         else $error("normal-mode channel did not pass the transmit level");
   end

endmodule : caf_filter

// >>> rtl/caf_pkg.sv
// constants, field layout and helper functions for the can acceptance filter
package caf_pkg;

   // ==========================================================
   // sizes
   localparam int unsigned NUM_CH  = 2;
   localparam int unsigned NUM_GRP = 8;

   // ==========================================================
   // register word indices (byte address = 4 * index)
   localparam logic [7:0] IDX_CTRL0    = 8'h00;
   localparam logic [7:0] IDX_CTRL1    = 8'h01;
   localparam logic [7:0] IDX_STAT0    = 8'h02;
   localparam logic [7:0] IDX_STAT1    = 8'h03;
   localparam logic [1:0] IDX_FLT_HI   = 2'h1;   // index[7:6] of the filter window

   // ==========================================================
   // control register fields
   localparam int unsigned CTRL_EN_BIT     = 0;
   localparam int unsigned CTRL_LISTEN_BIT = 1;
   localparam int unsigned CTRL_ERREC_BIT  = 2;
   localparam int unsigned CTRL_TRIPLE_BIT = 3;
   localparam int unsigned CTRL_SJW_LSB    = 4;
   localparam int unsigned CTRL_TSEG2_LSB  = 8;
   localparam int unsigned CTRL_TSEG1_LSB  = 12;
   localparam int unsigned CTRL_GRP_LSB    = 16;
   localparam int unsigned CTRL_TBAD_BIT   = 31;
   localparam logic [30:0] CTRL_WMASK      = 31'h00ff_f73f;
   localparam logic [30:0] CTRL_RST        = 31'h0000_0000;
   localparam logic [31:0] ACC_RST         = 32'h0000_0000;
   localparam logic [31:0] MSK_RST         = 32'h0000_0000;
   localparam logic [15:0] CNT_RST         = 16'h0000;

   // ==========================================================
   // compare word layout
   localparam int unsigned CW_EXT_BIT = 31;
   localparam int unsigned CW_REM_BIT = 30;
   localparam int unsigned CW_STD_LSB = 19;
   localparam int unsigned CW_XID_LSB = 1;

   function automatic logic [31:0] cmp_word(input logic [28:0] id, input logic extended_select_bit,
                                            input logic rtr);
      logic [31:0] w;
      w             = 32'h0000_0000;
      w[CW_EXT_BIT] = extended_select_bit;
      w[CW_REM_BIT] = rtr;
      if (extended_select_bit) begin
         w[CW_XID_LSB +: 29] = id;
      end else begin
         w[CW_STD_LSB +: 11] = id[10:0];
      end
      return w;
   endfunction : cmp_word

   function automatic logic grp_match(input logic [31:0] acc, input logic [31:0] msk,
                                      input logic [31:0] w);
      return ((acc ^ w) & msk) == 32'h0000_0000;
   endfunction : grp_match

   function automatic logic [31:0] apply_sel(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) r[8*b +: 8] = wd[8*b +: 8];
      end
      return r;
   endfunction : apply_sel

endpackage : caf_pkg

// >>> test/caf_rx_model.sv
// behavioural model of the controller receive path and its transmit levels
`timescale 1ns/1ps
module caf_rx_model (
   // clock
   input  wire logic        clk_i,
   // decoded frames
   output logic             rx_valid_o,
   output logic             rx_chan_o,
   output logic      [28:0] rx_id_o,
   output logic             rx_ext_o,
   output logic             rx_rtr_o,
   output logic             rx_err_o,
   // transmit request levels, 0 = dominant
   output logic      [1:0]  ctl_tx_o
);
   initial begin
      rx_valid_o = 1'b0;
      rx_chan_o  = 1'b0;
      rx_id_o    = 29'h0;
      rx_ext_o   = 1'b0;
      rx_rtr_o   = 1'b0;
      rx_err_o   = 1'b0;
      ctl_tx_o   = 2'h3;
   end

   // one strobe per frame, fields qualified by the strobe only
   task automatic send(input logic ch, input logic [28:0] id, input logic extended_select_bit,
                       input logic rtr, input logic err);
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_chan_o  <= ch;
      rx_id_o    <= id;
      rx_ext_o   <= extended_select_bit;
      rx_rtr_o   <= rtr;
      rx_err_o   <= err;
      @(posedge clk_i);
      // fields go stale once the strobe drops, so a late sample shows up
      rx_valid_o <= 1'b0;
      rx_chan_o  <= ~ch;
      rx_id_o    <= ~id;
      rx_ext_o   <= ~extended_select_bit;
      rx_rtr_o   <= ~rtr;
      rx_err_o   <= ~err;
   endtask : send

   task automatic drive_tx(input logic [1:0] v);
      @(posedge clk_i);
      ctl_tx_o <= v;
   endtask : drive_tx
endmodule : caf_rx_model

// >>> test/test_can_acceptance_filter.sv
// self-checking bench for the two-channel acceptance filter
`timescale 1ns/1ps
module test_can_acceptance_filter
   import caf_pkg::*;
;
   typedef struct packed {
      logic        ch;
      logic [28:0] id;
      logic        extended_select_bit;
      logic        rtr;
      logic        err;
      logic        exp;
   } caf_row_t;
   // ==========================================================
   // signals
   logic        clk_i    = 1'b0;
   logic        rst_i    = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i  = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o, rd;
   logic        wb_ack_o, rx_valid, rx_chan, rx_ext, rx_rtr, rx_err;
   logic [28:0] rx_id, rec_id_o;
   logic [1:0]  ctl_tx, can_tx_o;
   logic        rec_valid_o, rec_chan_o, rec_ext_o, rec_rtr_o, rec_err_o;
   int          n_mismatch = 0;
   int          compares   = 0;

   localparam caf_row_t ROWS [12] = '{
      '{1'b0, 29'h123, 1'b0, 1'b0, 1'b0, 1'b1},
      '{1'b0, 29'h122, 1'b0, 1'b0, 1'b0, 1'b0},
      '{1'b0, 29'h123, 1'b0, 1'b1, 1'b0, 1'b0},
      '{1'b0, 29'h1923, 1'b0, 1'b0, 1'b0, 1'b1},
      '{1'b0, 29'h123, 1'b1, 1'b0, 1'b0, 1'b0},
      '{1'b0, 29'h15555555, 1'b1, 1'b1, 1'b0, 1'b1},
      '{1'b0, 29'h15555554, 1'b1, 1'b1, 1'b0, 1'b0},
      '{1'b0, 29'h1fffffff, 1'b1, 1'b0, 1'b0, 1'b0},
      '{1'b0, 29'h0, 1'b0, 1'b0, 1'b1, 1'b0},
      '{1'b1, 29'h7ff, 1'b0, 1'b0, 1'b0, 1'b1},
      '{1'b1, 29'h123, 1'b0, 1'b0, 1'b0, 1'b0},
      '{1'b1, 29'h0, 1'b0, 1'b0, 1'b1, 1'b1}
   };

   always #50 clk_i = ~clk_i;

   caf_filter i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid), .rx_chan_i(rx_chan),
      .rx_id_i(rx_id), .rx_ext_i(rx_ext), .rx_rtr_i(rx_rtr), .rx_err_i(rx_err),
      .ctl_tx_i(ctl_tx), .rec_valid_o(rec_valid_o), .rec_chan_o(rec_chan_o),
      .rec_id_o(rec_id_o), .rec_ext_o(rec_ext_o), .rec_rtr_o(rec_rtr_o),
      .rec_err_o(rec_err_o), .can_tx_o(can_tx_o));

   caf_rx_model i_rx (.clk_i(clk_i), .rx_valid_o(rx_valid), .rx_chan_o(rx_chan),
      .rx_id_o(rx_id), .rx_ext_o(rx_ext), .rx_rtr_o(rx_rtr), .rx_err_o(rx_err),
      .ctl_tx_o(ctl_tx));

   // ==========================================================
   // helpers
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // classic single cycle, held until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) begin
         @(posedge clk_i);
      end
      chk("wb_ack", 32'h1, {31'h0, wb_ack_o});
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb

   task automatic frame(input caf_row_t r);
      i_rx.send(r.ch, r.id, r.extended_select_bit, r.rtr, r.err);
      #1;
      chk("rec_valid", {31'h0, r.exp}, {31'h0, rec_valid_o});
      if (r.exp) begin
         chk("rec_chan", {31'h0, r.ch}, {31'h0, rec_chan_o});
         chk("rec_err", {31'h0, r.err}, {31'h0, rec_err_o});
         if (!r.err) begin
            chk("rec_id", {3'h0, r.id}, {3'h0, rec_id_o});
            chk("rec_ext", {31'h0, r.extended_select_bit}, {31'h0, rec_ext_o});
            chk("rec_rtr", {31'h0, r.rtr}, {31'h0, rec_rtr_o});
         end
      end
   endtask : frame

   task automatic final_report;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : final_report

   // ==========================================================
   // tests
   initial begin
      repeat (7) @(posedge clk_i);
      #1;
      chk("can_tx_rst", 32'h3, {30'h0, can_tx_o});
      chk("ack_rst", 32'h0, {31'h0, wb_ack_o});
      chk("rec_valid_rst", 32'h0, {31'h0, rec_valid_o});
      @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, IDX_CTRL0, 32'h0);
      chk("ctrl0_rst", 32'h0, rd);
      $display("test reset done");
      wb(1'b1, 8'h40, 32'h0918_0000);
      wb(1'b1, 8'h41, 32'hfff8_0000);
      wb(1'b1, 8'h42, 32'hc000_0002);
      wb(1'b1, 8'h43, 32'hc000_0002);
      wb(1'b1, 8'h5e, 32'h3ff8_0000);
      wb(1'b1, 8'h5f, 32'hfff8_0000);
      // timing kept with phase two at least the jump width
      wb(1'b1, IDX_CTRL0, 32'h0003_0211);
      wb(1'b1, IDX_CTRL1, 32'h0080_0217);
      wb(1'b0, 8'h42, 32'h0);
      chk("acc_g1", 32'hc000_0002, rd);
      wb(1'b0, IDX_CTRL0, 32'h0);
      chk("ctrl0", 32'h0003_0211, rd);
      wb(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h0, rd);
      $display("test config done");
      foreach (ROWS[i]) frame(ROWS[i]);
      $display("test table done");
      wb(1'b0, IDX_STAT0, 32'h0);
      chk("stat0", 32'h0005_0003, rd);
      wb(1'b0, IDX_STAT1, 32'h0);
      chk("stat1", 32'h0001_0001, rd);
      wb(1'b1, IDX_STAT0, 32'h0);
      wb(1'b0, IDX_STAT0, 32'h0);
      chk("stat0_clr", 32'h0, rd);
      wb(1'b0, IDX_STAT1, 32'h0);
      chk("stat1_kept", 32'h0001_0001, rd);
      $display("test status done");
      i_rx.drive_tx(2'b00);
      repeat (2) @(posedge clk_i);
      #1;
      chk("can_tx", 32'h2, {30'h0, can_tx_o});
      $display("test bus drive done");
      wb(1'b1, IDX_CTRL0, 32'h0003_0210);
      frame(caf_row_t'{1'b0, 29'h123, 1'b0, 1'b0, 1'b0, 1'b0});
      chk("can_tx_off", 32'h3, {30'h0, can_tx_o});
      $display("test disable done");
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk("ack_rst2", 32'h0, {31'h0, wb_ack_o});
      chk("can_tx_rst2", 32'h3, {30'h0, can_tx_o});
      wb(1'b0, IDX_CTRL1, 32'h0);
      chk("ctrl1_rst2", 32'h0, rd);
      wb(1'b0, 8'h5e, 32'h0);
      chk("acc_rst2", 32'h0, rd);
      frame(caf_row_t'{1'b0, 29'h123, 1'b0, 1'b0, 1'b0, 1'b0});
      $display("test midrun reset done");
      // group 0 alone, so one group decides each frame
      wb(1'b1, IDX_CTRL0, 32'h0001_0001);
      frame(caf_row_t'{1'b0, 29'h123, 1'b0, 1'b0, 1'b0, 1'b1});
      wb(1'b1, 8'h40, 32'h0918_0000);
      wb(1'b1, 8'h41, 32'h3ff8_0000);
      frame(caf_row_t'{1'b0, 29'h123, 1'b0, 1'b0, 1'b0, 1'b1});
      frame(caf_row_t'{1'b0, 29'h124, 1'b0, 1'b0, 1'b0, 1'b0});
      @(posedge clk_i);
      wb_sel_i <= 4'h8;
      wb(1'b1, 8'h40, 32'hc0ff_ffff);
      wb_sel_i <= 4'hf;
      wb(1'b0, 8'h40, 32'h0);
      chk("acc_sel", 32'hc018_0000, rd);
      wb(1'b1, 8'h41, 32'hc000_0000);
      frame(caf_row_t'{1'b0, 29'h123, 1'b0, 1'b0, 1'b0, 1'b0});
      frame(caf_row_t'{1'b0, 29'h5, 1'b1, 1'b1, 1'b0, 1'b1});
      wb(1'b1, 8'h40, 32'h0000_0002);
      wb(1'b1, 8'h41, 32'h0000_0002);
      frame(caf_row_t'{1'b0, 29'h2, 1'b1, 1'b0, 1'b0, 1'b0});
      frame(caf_row_t'{1'b0, 29'h3, 1'b1, 1'b0, 1'b0, 1'b1});
      $display("test single group done");
      final_report();
   end

   initial begin
      #(3000 * 100);
      n_mismatch++;
      final_report();
   end
endmodule : test_can_acceptance_filter
